// >>> hw/adc_seq_pkg.sv
// Constants and types for the serial converter sequencing block.
package adc_seq_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESULT_BITS = 16;
    // Longest busy-low time, in microseconds.
    localparam int BUSY_LOW_MAX_US = 3;
    localparam int BUSY_LOW_CYC = (BUSY_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
    // Delay from end of conversion to busy rising, in nanoseconds.
    localparam int BUSY_DELAY_NS = 100;
    localparam int BUSY_DELAY_CYC = (BUSY_DELAY_NS / CLK_PERIOD_NS) < 1 ?
        1 : BUSY_DELAY_NS / CLK_PERIOD_NS;
    // Internal conversion time; busy rises after it plus the busy delay.
    localparam int CONV_CYC = BUSY_LOW_CYC - BUSY_DELAY_CYC;
    // Start-to-first internal shift clock delay, in nanoseconds.
    localparam int SCLK_DELAY_NS = 260;
    localparam int SCLK_DELAY_CYC = (SCLK_DELAY_NS / CLK_PERIOD_NS) < 1 ?
        1 : SCLK_DELAY_NS / CLK_PERIOD_NS;
    // Internal shift clock period, in nanoseconds; one half per cycle min.
    localparam int SCLK_PERIOD_NS = 150;
    localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2 / CLK_PERIOD_NS) < 1 ?
        1 : SCLK_PERIOD_NS / 2 / CLK_PERIOD_NS;
    // Least time the old result stays valid after a start, in nanoseconds.
    localparam int OLD_VALID_NS = 2200;
    localparam int OLD_VALID_CYC = (OLD_VALID_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] SIGN_FLIP = 16'h8000;
    localparam logic [4:0] PULSE_COUNT = 5'h10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b10
    } conv_state_t;
endpackage

// >>> hw/word_buffer.sv
// Two-entry valid/ready buffer for converted result words.
`timescale 1ns/1ps
module word_buffer #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t cur;
    buf_state_t next_cur;
    logic push;
    logic pop;

    assign in_ready = (cur.count != 2'h2);
    assign out_valid = (cur.count != 2'h0);
    assign out_data = cur.mem[0];
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;

    always_comb begin
        next_cur = cur;
        if (pop) begin
            next_cur.mem[0] = cur.mem[1];
        end
        if (push) begin
            if (pop) begin
                next_cur.mem[cur.count - 2'h1] = in_data;
            end else begin
                next_cur.mem[cur.count[0]] = in_data;
            end
        end
        next_cur.count = cur.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
endmodule

// >>> hw/adc_conv_seq.sv
// Conversion sequencing and serial result output for a 16-bit SAR converter.
//
// Function
// - Read/convert fall with select low starts conversion.
// - Busy low at most 3 us, late 100 ns.
// - Internal shift clock starts 260 ns, period 150; here it starts 200 ns after busy falls, with a period of 200 ns.
// - Previous result stays valid at least 2.2 us.
// - Coding: offset binary or two's complement zero.
// - Exactly sixteen internal pulses, low between conversions.
// - Select fall with read/convert low starts conversion.
// - Sleep request blocks starts and keeps result.
`timescale 1ns/1ps
module adc_conv_seq
    import adc_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic read_convert,
    input wire logic select_n,
    input wire logic sleep_request,
    input wire logic shift_clock_source_sel,
    input wire logic output_code_format_sel,
    input wire logic shift_clock_in,
    input wire logic [15:0] sar_result,
    output logic busy_n,
    output logic shift_clock_out,
    output logic shift_clock_oe,
    output logic data_out,
    output logic result_valid,
    input wire logic result_ready,
    output logic [15:0] result_word
);
    typedef struct packed {
        logic [1:0] rc_sync;
        logic [1:0] cs_sync;
        logic [1:0] pd_sync;
        logic [1:0] ck_sync;
        logic [1:0] src_sync;
        logic [1:0] fmt_sync;
        logic start_ok;
        logic ck_last;
        conv_state_t state;
        logic [7:0] timer;
        logic [7:0] sclk_timer;
        logic [4:0] pulses;
        logic sclk;
        logic [15:0] shreg;
        logic [15:0] result;
        logic busy_n;
        logic push;
        logic load_due;
    } seq_state_t;

    seq_state_t cur;
    seq_state_t next_cur;
    logic start_level;
    logic start_edge;
    logic ext_edge;
    logic buf_ready;
    logic [15:0] coded;
    logic shifting;
    localparam int BUSY_RISE_MAX = BUSY_LOW_CYC + 1;

    // Both inputs are or'd internally, so either falling edge can start.
    assign start_level = ~(cur.rc_sync[1] | cur.cs_sync[1]);
    assign start_edge = start_level && cur.start_ok;
    assign ext_edge = cur.ck_sync[1] && !cur.ck_last;
    // Straight binary flips the top bit of the two's complement result.
    assign coded = cur.fmt_sync[1] ? (sar_result ^ SIGN_FLIP) :
        sar_result;
    // At this clock sixteen pulses outlast busy by a few cycles, so the
    // clock runs on until the last one and then stays low.
    assign shifting = !cur.src_sync[1] && cur.pulses != PULSE_COUNT &&
        (cur.state != ST_IDLE || cur.sclk_timer != 8'h00);

    always_comb begin
        next_cur = cur;
        next_cur.rc_sync = {cur.rc_sync[0], read_convert};
        next_cur.cs_sync = {cur.cs_sync[0], select_n};
        next_cur.pd_sync = {cur.pd_sync[0], sleep_request};
        next_cur.ck_sync = {cur.ck_sync[0], shift_clock_in};
        next_cur.src_sync = {cur.src_sync[0], shift_clock_source_sel};
        next_cur.fmt_sync = {cur.fmt_sync[0], output_code_format_sel};
        next_cur.ck_last = cur.ck_sync[1];
        next_cur.start_ok = !start_level;
        next_cur.push = 1'b0;
        case (cur.state)
            ST_IDLE: begin
                // A start in sleep is dropped and the result is kept.
                if (start_edge && !cur.pd_sync[1]) begin
                    next_cur.state = ST_CONV;
                    next_cur.timer = 8'h00;
                    next_cur.busy_n = 1'b0;
                    next_cur.pulses = 5'h00;
                    next_cur.sclk_timer = 8'h00;
                end
            end
            ST_CONV: begin
                next_cur.timer = cur.timer + 8'h01;
                if (cur.timer == 8'(CONV_CYC - 1)) begin
                    next_cur.state = ST_DONE;
                    next_cur.timer = 8'h00;
                    next_cur.result = coded;
                end
            end
            ST_DONE: begin
                next_cur.timer = cur.timer + 8'h01;
                if (cur.timer == 8'(BUSY_DELAY_CYC - 1)) begin
                    next_cur.state = ST_IDLE;
                    next_cur.busy_n = 1'b1;
                    next_cur.load_due = 1'b1;
                    next_cur.push = 1'b1;
                end
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
        // Internal mode shifts the previous word out during conversion.
        if (shifting) begin
            next_cur.sclk_timer = cur.sclk_timer + 8'h01;
            if (cur.sclk_timer == 8'(SCLK_DELAY_CYC - 1)) begin
                next_cur.sclk = 1'b1;
            end else if (cur.sclk_timer >= 8'(SCLK_DELAY_CYC) &&
                ((cur.sclk_timer - 8'(SCLK_DELAY_CYC - 1)) %
                8'(SCLK_HALF_CYC)) == 8'h00) begin
                next_cur.sclk = !cur.sclk;
                if (cur.sclk) begin
                    next_cur.pulses = cur.pulses + 5'h01;
                    next_cur.shreg = {cur.shreg[14:0], 1'b0};
                end
            end
        end else begin
            next_cur.sclk = 1'b0;
        end
        // External mode advances on the sampled host clock edge.
        if (cur.src_sync[1] && ext_edge && !cur.cs_sync[1] &&
            cur.rc_sync[1]) begin
            next_cur.shreg = {cur.shreg[14:0], 1'b0};
        end
        // In internal mode the new word waits until the old one has left on the clock; external mode loads it at once.
        if (cur.load_due &&
            (cur.src_sync[1] || cur.pulses == PULSE_COUNT)) begin
            next_cur.shreg = cur.result;
            next_cur.load_due = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.rc_sync <= 2'h3;
            cur.cs_sync <= 2'h3;
            cur.busy_n <= 1'b1;
            cur.state <= ST_IDLE;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign busy_n = cur.busy_n;
    assign shift_clock_out = cur.sclk;
    assign shift_clock_oe = !cur.src_sync[1];
    assign data_out = cur.shreg[15];

    word_buffer #(
        .WIDTH(RESULT_BITS)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(cur.push),
        .in_ready(buf_ready),
        .in_data(cur.result),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_word)
    );

    default clocking cb_seq @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_start;
        cur.state == ST_IDLE && start_edge && !cur.pd_sync[1] && clk_en;
    endsequence

    chk_busy_falls: assert property (s_start |=> !busy_n)
        else $error("busy did not fall after start");

    chk_busy_low_max: assert property (
        s_start |-> ##[1:BUSY_RISE_MAX] busy_n)
        else $error("busy low too long");

    chk_sleep_blocks: assert property (
        (busy_n && cur.pd_sync[1] && clk_en) |=> busy_n)
        else $error("conversion started during sleep");

    // Four idle cycles leave room for the pulses that outlast busy.
    chk_sclk_idle_low: assert property (
        (busy_n && $past(busy_n, 4) && cur.state == ST_IDLE) |=>
        (!shift_clock_out || !busy_n))
        else $error("shift clock high between conversions");

    chk_old_data_hold: assert property (
        (s_start and cur.src_sync[1]) |=> $stable(data_out)[*8])
        else $error("previous data changed too early");

    chk_sclk_delay: assert property (
        (s_start and !cur.src_sync[1]) |=>
        !shift_clock_out[*2] ##1 shift_clock_out)
        else $error("shift clock start delay wrong");

    chk_code_format: assert property (
        (cur.state == ST_CONV && next_cur.state == ST_DONE && clk_en) |=>
        cur.result[15] == ($past(sar_result[15]) ^ $past(cur.fmt_sync[1])))
        else $error("output coding wrong");

    chk_push_ready: assert property (cur.push |-> buf_ready)
        else $error("result buffer overflow");
endmodule

// >>> dv/adc_host_model.sv
// Host model: convert strobes, acquisition spacing, external shift clock.
`timescale 1ns/1ps
module adc_host_model (
    input wire logic ref_clk,
    input wire logic busy_n,
    input wire logic data_out,
    output logic read_convert,
    output logic select_n,
    output logic shift_clock_in
);
    initial begin
        read_convert = 1'b1;
        select_n = 1'b1;
        shift_clock_in = 1'b0;
    end
    task automatic start(input logic sel_last);
        @(negedge ref_clk);
        if (sel_last) read_convert = 1'b0; else select_n = 1'b0;
        @(negedge ref_clk);
        if (sel_last) select_n = 1'b0; else read_convert = 1'b0;
        repeat (5) @(negedge ref_clk);
        read_convert = 1'b1;
        select_n = 1'b1;
    endtask
    task automatic finish(output logic ok);
        int n;
        n = 0;
        while (busy_n !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        ok = busy_n;
        repeat (20) @(negedge ref_clk);
    endtask
    // Shifting does not wait for busy high; it starts at once, even during a conversion.
    task automatic shift_word(output logic [15:0] w);
        select_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            #400;
            w = {w[14:0], data_out};
            shift_clock_in = 1'b1;
            #400;
            shift_clock_in = 1'b0;
        end
        select_n = 1'b1;
    endtask
endmodule

// >>> dv/adc_conv_seq_test.sv
// Self-checking bench for the converter sequencing block.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module adc_conv_seq_test;
    import adc_seq_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic sleep_request = 1'b0;
    logic shift_clock_source_sel = 1'b1;
    logic output_code_format_sel = 1'b0;
    logic result_ready = 1'b0;
    logic [15:0] sar_result = 16'h0000;
    logic read_convert, select_n, shift_clock_in, busy_n, shift_clock_out;
    logic shift_clock_oe, data_out, result_valid, ok, prev_sc;
    logic [15:0] result_word, got, int_bits;
    int errors = 0;
    int checks_done = 0;
    int low_cnt = 0;
    int rises = 0;
    int cyc = 0;
    int first_rise = 0;
    always #50 ref_clk = ~ref_clk;
    adc_conv_seq i_adc_conv_seq (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .read_convert(read_convert), .select_n(select_n),
        .sleep_request(sleep_request),
        .shift_clock_source_sel(shift_clock_source_sel),
        .output_code_format_sel(output_code_format_sel),
        .shift_clock_in(shift_clock_in), .sar_result(sar_result),
        .busy_n(busy_n), .shift_clock_out(shift_clock_out),
        .shift_clock_oe(shift_clock_oe), .data_out(data_out),
        .result_valid(result_valid), .result_ready(result_ready),
        .result_word(result_word));
    adc_host_model i_host (.ref_clk(ref_clk), .busy_n(busy_n),
        .data_out(data_out), .read_convert(read_convert),
        .select_n(select_n), .shift_clock_in(shift_clock_in));
    always @(posedge ref_clk) begin
        cyc++;
        prev_sc <= shift_clock_out;
        if (busy_n === 1'b0) low_cnt++;
        if (shift_clock_out === 1'b1 && prev_sc === 1'b0) begin
            rises++;
            int_bits = {int_bits[14:0], data_out};
            if (rises == 1) first_rise = cyc;
        end
    end
    task automatic arm(input logic src, input logic fmt, input logic [15:0] v);
        @(negedge ref_clk);
        shift_clock_source_sel = src;
        output_code_format_sel = fmt;
        sar_result = v;
        low_cnt = 0;
        rises = 0;
    endtask
    // The result is left in the buffer; the drain test reads it later.
    task automatic t_external;
        arm(1'b1, 1'b0, 16'hA5C3);
        i_host.start(1'b0);
        i_host.finish(ok);
        `CHK(ok, 1'b1)
        `CHK(low_cnt inside {[1:30]}, 1'b1)
        `CHK(shift_clock_oe, 1'b0)
        `CHK(rises, 0)
        $display("t_external done");
    endtask
    task automatic t_internal;
        int t0;
        arm(1'b0, 1'b1, 16'h0001);
        t0 = cyc;
        i_host.start(1'b1);
        i_host.finish(ok);
        `CHK(ok, 1'b1)
        `CHK(low_cnt inside {[1:30]}, 1'b1)
        `CHK(first_rise - t0 inside {[2:9]}, 1'b1)
        `CHK(rises, 16)
        `CHK(int_bits, 16'hA5C3)
        `CHK(shift_clock_out, 1'b0)
        `CHK(shift_clock_oe, 1'b1)
        $display("t_internal done");
    endtask
    task automatic t_sleep;
        arm(1'b1, 1'b1, 16'h7FFF);
        sleep_request = 1'b1;
        i_host.start(1'b0);
        repeat (40) @(negedge ref_clk);
        `CHK(low_cnt, 0)
        i_host.shift_word(got);
        `CHK(got, 16'h8001)
        sleep_request = 1'b0;
        $display("t_sleep done");
    endtask
    // Ready high must not pop a word while the enable holds everything.
    task automatic t_freeze;
        @(negedge ref_clk);
        clk_en = 1'b0;
        result_ready = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(result_valid, 1'b1)
        `CHK(result_word, 16'hA5C3)
        `CHK(busy_n, 1'b1)
        result_ready = 1'b0;
        clk_en = 1'b1;
        $display("t_freeze done");
    endtask
    // Two words waited with ready low; neither may be lost.
    task automatic t_drain;
        `CHK(result_valid, 1'b1)
        `CHK(result_word, 16'hA5C3)
        result_ready = 1'b1;
        @(negedge ref_clk);
        `CHK(result_valid, 1'b1)
        `CHK(result_word, 16'h8001)
        @(negedge ref_clk);
        result_ready = 1'b0;
        `CHK(result_valid, 1'b0)
        $display("t_drain done");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_external;
        t_internal;
        t_sleep;
        t_freeze;
        t_drain;
        close_out;
    end
    // About 300 cycles are expected; this allows several times that.
    initial begin
        #300000;
        errors++;
        close_out;
    end
endmodule
